/* File: common/p2gp_pkg.sv */
// p2gp_pkg: register map, field positions and reset values of the port 2 block
// assumes 16-bit register addresses and byte-wide register data
package p2gp_pkg;

  // ---------------------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PINS   = 8;

  // ---------------------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PIN_FUNCTION_SELECT_ADDR = 16'hffc9;
  localparam logic [ADDR_W-1:0] OUTPUT_DRIVE_TYPE_ADDR   = 16'hffcb;
  localparam logic [ADDR_W-1:0] PORT_DATA_LATCH_ADDR     = 16'hffd5;
  localparam logic [ADDR_W-1:0] PIN_DIRECTION_ADDR       = 16'hffe5;

  // ---------------------------------------------------------------------------
  // reset values and fixed read values
  // ---------------------------------------------------------------------------
  localparam logic [DATA_W-1:0] PIN_FUNCTION_SELECT_RST = 8'hc0;
  localparam logic [DATA_W-1:0] OUTPUT_DRIVE_TYPE_RST   = 8'h00;
  localparam logic [DATA_W-1:0] PORT_DATA_LATCH_RST     = 8'h00;
  localparam logic [DATA_W-1:0] PIN_DIRECTION_RST       = 8'h00;
  localparam logic [DATA_W-1:0] PIN_DIRECTION_READ      = 8'hff;
  localparam logic [DATA_W-1:0] UNMAPPED_READ           = 8'h00;
  // bits of pin_function_select that hold state; 7 and 6 are fixed ones
  localparam logic [DATA_W-1:0] PFS_WRITE_MASK          = 8'h3f;
  localparam logic [DATA_W-1:0] PFS_FIXED_ONES          = 8'hc0;

  // ---------------------------------------------------------------------------
  // pin_function_select fields
  // ---------------------------------------------------------------------------
  localparam int unsigned EXT_INTERRUPT_ZERO_SELECT_BIT = 3;
  localparam int unsigned SERIAL_OUT_PULLUP_OFF_BIT     = 2;
  localparam int unsigned UPDOWN_INPUT_SELECT_BIT       = 1;
  localparam int unsigned EXT_INTERRUPT_FOUR_SELECT_BIT = 0;
  localparam int unsigned UPDOWN_PIN                    = 1;
  localparam int unsigned EXT_INTERRUPT_FOUR_PIN        = 0;

  typedef logic [DATA_W-1:0] p2gp_byte_t;

endpackage : p2gp_pkg

/* File: common/p2gp_cfg_if.sv */
// p2gp_cfg_if: register contents handed from the register file to the pad logic
// assumes a single clock; all signals are register outputs
`timescale 1ns/1ps
interface p2gp_cfg_if;
  import p2gp_pkg::*;

  p2gp_byte_t data_latch;
  p2gp_byte_t direction;
  p2gp_byte_t drive_type;
  p2gp_byte_t function_select;

  modport regs (output data_latch, direction, drive_type, function_select);
  modport pads (input  data_latch, direction, drive_type, function_select);
endinterface : p2gp_cfg_if

/* File: rtl/p2gp_regs.sv */
// p2gp_regs: the four port 2 registers and their write behaviour
// assumes write strobes are already qualified by address; clk_en is applied here on the register update
`timescale 1ns/1ps
module p2gp_regs
  import p2gp_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // write port
  input  wire logic wr_data_latch,
  input  wire logic wr_direction,
  input  wire logic wr_drive_type,
  input  wire logic wr_function_select,
  input  wire p2gp_byte_t wdata,
  // register contents
  p2gp_cfg_if.regs cfg
);

  typedef struct packed {
    p2gp_byte_t data_latch;
    p2gp_byte_t direction;
    p2gp_byte_t drive_type;
    p2gp_byte_t function_select;
  } p2gp_regs_state_t;

  p2gp_regs_state_t state_reg;
  p2gp_regs_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    if (wr_data_latch)
    begin
      state_next.data_latch = wdata;
    end
    if (wr_direction)
    begin
      state_next.direction = wdata;
    end
    if (wr_drive_type)
    begin
      state_next.drive_type = wdata;
    end
    if (wr_function_select)
    begin
      // upper two bits never change
      state_next.function_select = (wdata & PFS_WRITE_MASK) | PFS_FIXED_ONES;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg.data_latch      <= PORT_DATA_LATCH_RST;
      state_reg.direction       <= PIN_DIRECTION_RST;
      state_reg.drive_type      <= OUTPUT_DRIVE_TYPE_RST;
      state_reg.function_select <= PIN_FUNCTION_SELECT_RST;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
    end
  end

  assign cfg.data_latch      = state_reg.data_latch;
  assign cfg.direction       = state_reg.direction;
  assign cfg.drive_type      = state_reg.drive_type;
  assign cfg.function_select = state_reg.function_select;

endmodule : p2gp_regs

/* File: rtl/p2gp_pads.sv */
// p2gp_pads: per-pin output drive, enables and alternate input routing
// assumes pad inputs are synchronous to clk; purely combinational
`timescale 1ns/1ps
module p2gp_pads
  import p2gp_pkg::*;
(
  // register contents
  p2gp_cfg_if.pads cfg,
  // pad side
  output wire p2gp_byte_t pin_out,
  output wire p2gp_byte_t pin_oe,
  output wire p2gp_byte_t general_io
);

  p2gp_byte_t gio;

  always_comb
  begin
    gio = '1;
    gio[UPDOWN_PIN]             = ~cfg.function_select[UPDOWN_INPUT_SELECT_BIT];
    gio[EXT_INTERRUPT_FOUR_PIN] = ~cfg.function_select[EXT_INTERRUPT_FOUR_SELECT_BIT];
  end

  // open-drain pins only sink: drive low while latch is 0, release otherwise
  assign pin_out    = cfg.data_latch & ~cfg.drive_type;
  assign pin_oe     = cfg.direction & gio & ~(cfg.drive_type & cfg.data_latch);
  assign general_io = gio;

endmodule : p2gp_pads

/* File: rtl/p2gp_top.sv */
// p2gp_top: port 2 general i/o with pin function select and drive type
// assumes a byte register port with one-cycle strobes and pads synchronous to clk
`timescale 1ns/1ps
module p2gp_top
  import p2gp_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire p2gp_byte_t        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output wire p2gp_byte_t        reg_rdata,
  // port pins
  input  wire p2gp_byte_t        port_pin_in,
  output wire p2gp_byte_t        port_pin_out,
  output wire p2gp_byte_t        port_pin_oe,
  // other-port pin routed as interrupt 0
  input  wire logic              other_port_pin_in,
  output wire logic              other_port_general_in,
  output wire logic              ext_interrupt_zero_in,
  // alternate inputs taken from port pins
  output wire logic              updown_count_in,
  output wire logic              ext_interrupt_four_in,
  output wire logic              converter_ext_trigger,
  // serial output pin buffer
  input  wire logic              serial_out_data,
  output wire logic              serial_output_pin_out,
  output wire logic              serial_output_pin_oe,
  output wire logic              serial_out_pullup_off
);

  // ---------------------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------------------
  logic [1:0] rst_sync_reg;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_sync_reg <= 2'h0;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  wire logic rst_n = rst_sync_reg[1];

  // ---------------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    hit = (a == r);
  endfunction : hit

  logic wr_data_latch;
  logic wr_direction;
  logic wr_drive_type;
  logic wr_function_select;

  always_comb
  begin
    wr_data_latch      = 1'b0;
    wr_direction       = 1'b0;
    wr_drive_type      = 1'b0;
    wr_function_select = 1'b0;
    if (reg_wr && hit(reg_addr, PORT_DATA_LATCH_ADDR))
    begin
      wr_data_latch = 1'b1;
    end
    else if (reg_wr && hit(reg_addr, PIN_DIRECTION_ADDR))
    begin
      wr_direction = 1'b1;
    end
    else if (reg_wr && hit(reg_addr, OUTPUT_DRIVE_TYPE_ADDR))
    begin
      wr_drive_type = 1'b1;
    end
    else if (reg_wr && hit(reg_addr, PIN_FUNCTION_SELECT_ADDR))
    begin
      wr_function_select = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // registers and pads
  // ---------------------------------------------------------------------------
  p2gp_cfg_if cfg ();

  p2gp_regs u_regs (
    .clk                (clk),
    .rst_n              (rst_n),
    .clk_en             (clk_en),
    .wr_data_latch      (wr_data_latch),
    .wr_direction       (wr_direction),
    .wr_drive_type      (wr_drive_type),
    .wr_function_select (wr_function_select),
    .wdata              (reg_wdata),
    .cfg                (cfg.regs)
  );

  p2gp_byte_t general_io;

  p2gp_pads u_pads (
    .cfg        (cfg.pads),
    .pin_out    (port_pin_out),
    .pin_oe     (port_pin_oe),
    .general_io (general_io)
  );

  // ---------------------------------------------------------------------------
  // read path and registered input routing
  // ---------------------------------------------------------------------------
  typedef struct packed {
    p2gp_byte_t rdata;
    logic       updown;
    logic       ext_interrupt_four_select;
    logic       ext_interrupt_zero_select;
    logic       other_in;
  } p2gp_top_state_t;

  p2gp_top_state_t state_reg;
  p2gp_top_state_t state_next;
  p2gp_byte_t      port_read;

  always_comb
  begin
    // output pins read back the latch, input pins the pad level
    port_read = (cfg.direction & cfg.data_latch) | (~cfg.direction & port_pin_in);
    state_next = state_reg;
    // read data live only in the cycle after the strobe
    state_next.rdata = UNMAPPED_READ;
    if (reg_rd)
    begin
      if (hit(reg_addr, PORT_DATA_LATCH_ADDR))
      begin
        state_next.rdata = port_read;
      end
      else if (hit(reg_addr, PIN_DIRECTION_ADDR))
      begin
        state_next.rdata = PIN_DIRECTION_READ;
      end
      else if (hit(reg_addr, OUTPUT_DRIVE_TYPE_ADDR))
      begin
        state_next.rdata = cfg.drive_type;
      end
      else if (hit(reg_addr, PIN_FUNCTION_SELECT_ADDR))
      begin
        state_next.rdata = cfg.function_select | PFS_FIXED_ONES;
      end
    end
    state_next.updown   = ~general_io[UPDOWN_PIN] & port_pin_in[UPDOWN_PIN];
    state_next.ext_interrupt_four_select     = ~general_io[EXT_INTERRUPT_FOUR_PIN] & port_pin_in[EXT_INTERRUPT_FOUR_PIN];
    state_next.ext_interrupt_zero_select     = cfg.function_select[EXT_INTERRUPT_ZERO_SELECT_BIT] & other_port_pin_in;
    state_next.other_in = ~cfg.function_select[EXT_INTERRUPT_ZERO_SELECT_BIT] & other_port_pin_in;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata             = state_reg.rdata;
  assign updown_count_in       = state_reg.updown;
  assign ext_interrupt_four_in = state_reg.ext_interrupt_four_select;
  assign converter_ext_trigger = state_reg.ext_interrupt_four_select;
  assign ext_interrupt_zero_in = state_reg.ext_interrupt_zero_select;
  assign other_port_general_in = state_reg.other_in;

  // ---------------------------------------------------------------------------
  // serial output buffer
  // ---------------------------------------------------------------------------
  wire logic so_pullup_off = cfg.function_select[SERIAL_OUT_PULLUP_OFF_BIT];

  assign serial_out_pullup_off = so_pullup_off;
  assign serial_output_pin_out = serial_out_data & ~so_pullup_off;
  assign serial_output_pin_oe  = ~(so_pullup_off & serial_out_data);

endmodule : p2gp_top

/* File: verification/p2gp_pin_model.sv */
// p2gp_pin_model: the board side of the eight port pins
// assumes ext_level is what outside drivers put on pins the port has released
`timescale 1ns/1ps
module p2gp_pin_model
  import p2gp_pkg::*;
(
  // pad side of the port
  input  wire p2gp_byte_t pin_out,
  input  wire p2gp_byte_t pin_oe,
  // outside drivers
  input  wire p2gp_byte_t ext_level,
  // level seen on each pin
  output wire p2gp_byte_t pin_level
);
  // a driven pin shows the port's value, a released one the outside level
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : p2gp_pin_model

/* File: verification/p2gp_top_sva.sv */
// p2gp_top_sva: port-level checks of the port 2 block
// assumes the pins hold still whenever clk_en is low, so frozen outputs still match them
`timescale 1ns/1ps
module p2gp_top_sva
  import p2gp_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              clk_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire p2gp_byte_t        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire p2gp_byte_t        reg_rdata,
  input wire p2gp_byte_t        port_pin_in,
  input wire p2gp_byte_t        port_pin_out,
  input wire p2gp_byte_t        port_pin_oe,
  input wire logic              other_port_pin_in,
  input wire logic              other_port_general_in,
  input wire logic              ext_interrupt_zero_in,
  input wire logic              updown_count_in,
  input wire logic              ext_interrupt_four_in,
  input wire logic              converter_ext_trigger,
  input wire logic              serial_out_data,
  input wire logic              serial_output_pin_out,
  input wire logic              serial_output_pin_oe,
  input wire logic              serial_out_pullup_off
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_rd(logic [ADDR_W-1:0] a);
    reg_rd && reg_addr == a;
  endsequence

  a_serial_out_gate: assert property (serial_output_pin_out == (serial_out_data & ~serial_out_pullup_off))
    else $error("serial pin value wrong");
  a_serial_release: assert property (serial_output_pin_oe == !(serial_out_pullup_off && serial_out_data))
    else $error("serial pin enable wrong");
  a_trigger_copy: assert property (converter_ext_trigger == ext_interrupt_four_in)
    else $error("trigger differs from interrupt four");
  a_irq_zero_src: assert property (ext_interrupt_zero_in |-> $past(other_port_pin_in) && !other_port_general_in)
    else $error("interrupt zero not from other pin");
  a_plain_in_src: assert property (other_port_general_in |-> $past(other_port_pin_in))
    else $error("plain input not from other pin");
  // enable is taken from the same edge as the level: a function change moves the pad at once
  a_updown_src: assert property (updown_count_in |-> $past(port_pin_in[1]) && !$past(port_pin_oe[1]))
    else $error("updown input wrong");
  a_irq_four_src: assert property (ext_interrupt_four_in |-> $past(port_pin_in[0]) && !$past(port_pin_oe[0]))
    else $error("interrupt four input wrong");
  a_dir_reads_ones: assert property (s_rd(PIN_DIRECTION_ADDR) |=> reg_rdata == PIN_DIRECTION_READ)
    else $error("direction read not all ones");
  a_fs_top_ones: assert property (s_rd(PIN_FUNCTION_SELECT_ADDR) |=> reg_rdata[7:6] == 2'b11)
    else $error("function select top bits not one");
  a_latch_out_read: assert property (s_rd(PORT_DATA_LATCH_ADDR) |=>
    ((reg_rdata ^ $past(port_pin_out)) & $past(port_pin_oe)) == 8'h00)
    else $error("driven pin read differs from latch");
endmodule : p2gp_top_sva

/* File: verification/test_port2_gpio_and_pin_select.sv */
// test_port2_gpio_and_pin_select: self-checking bench of the port 2 block
// assumes the pin model closes the pad loop; clk_en drops low once to check the freeze
`timescale 1ns/1ps
module test_port2_gpio_and_pin_select;
  import p2gp_pkg::*;
  typedef struct packed {logic [ADDR_W-1:0] a; p2gp_byte_t w; p2gp_byte_t ext; p2gp_byte_t exp;} p2gp_row_t;
  logic clk = 0, reset_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic other_port_pin_in = 0, serial_out_data = 0;
  logic other_port_general_in, ext_interrupt_zero_in, updown_count_in;
  logic ext_interrupt_four_in, converter_ext_trigger;
  logic serial_output_pin_out, serial_output_pin_oe, serial_out_pullup_off;
  logic [ADDR_W-1:0] reg_addr = 16'h0000;
  p2gp_byte_t reg_wdata = 8'h00, ext_level = 8'h00, reg_rdata, port_pin_in, port_pin_out, port_pin_oe, v;
  int num_errors = 0, check_count = 0, cyc = 0;
  // state builds up row by row; the last row needs direction 0x0f from row 6
  p2gp_row_t rows [9] = '{
    '{PIN_FUNCTION_SELECT_ADDR, 8'h00, 8'h00, 8'hc0}, '{PIN_FUNCTION_SELECT_ADDR, 8'h0f, 8'h00, 8'hcf},
    '{PIN_FUNCTION_SELECT_ADDR, 8'h00, 8'h00, 8'hc0}, '{OUTPUT_DRIVE_TYPE_ADDR, 8'ha5, 8'h00, 8'ha5},
    '{OUTPUT_DRIVE_TYPE_ADDR, 8'h0f, 8'h00, 8'h0f}, '{PORT_DATA_LATCH_ADDR, 8'h3c, 8'h96, 8'h96},
    '{PIN_DIRECTION_ADDR, 8'h0f, 8'h96, 8'hff}, '{16'hffca, 8'h55, 8'h03, 8'h00},
    '{PORT_DATA_LATCH_ADDR, 8'h3c, 8'h03, 8'h0c}};

  always #2.5 clk = ~clk;

  p2gp_top p2gp_top_i (
    .clk                   (clk),
    .reset_n               (reset_n),
    .clk_en                (clk_en),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_rdata             (reg_rdata),
    .port_pin_in           (port_pin_in),
    .port_pin_out          (port_pin_out),
    .port_pin_oe           (port_pin_oe),
    .other_port_pin_in     (other_port_pin_in),
    .other_port_general_in (other_port_general_in),
    .ext_interrupt_zero_in (ext_interrupt_zero_in),
    .updown_count_in       (updown_count_in),
    .ext_interrupt_four_in (ext_interrupt_four_in),
    .converter_ext_trigger (converter_ext_trigger),
    .serial_out_data       (serial_out_data),
    .serial_output_pin_out (serial_output_pin_out),
    .serial_output_pin_oe  (serial_output_pin_oe),
    .serial_out_pullup_off (serial_out_pullup_off)
  );
  p2gp_pin_model p2gp_pin_model_i (.pin_out(port_pin_out), .pin_oe(port_pin_oe), .ext_level(ext_level),
    .pin_level(port_pin_in));

  // ---------------------------------------------------------------------------
  // bus, compare and closing tasks
  // ---------------------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input p2gp_byte_t d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output p2gp_byte_t d);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk);
  endtask : rd
  task automatic chk(input string n, input p2gp_byte_t seen, input p2gp_byte_t exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic rst();
    reset_n <= 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : rst
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // a hang costs one mismatch and ends the run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      test_done();
    end
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    rst();
    foreach (rows[i])
    begin
      ext_level <= rows[i].ext;
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, v);
      chk("row read", v, rows[i].exp);
    end
    // open drain releases latch ones, push-pull pins off
    chk("pin enable", port_pin_oe, 8'h03);
    chk("pin value", port_pin_out, 8'h30);
    wr(PIN_FUNCTION_SELECT_ADDR, 8'h03);
    settle(2);
    chk("alt pin enable", port_pin_oe, 8'h00);
    chk("updown", {7'h00, updown_count_in}, 8'h01);
    chk("irq four", {7'h00, ext_interrupt_four_in}, 8'h01);
    chk("trigger", {7'h00, converter_ext_trigger}, 8'h01);
    // settle leaves us mid-cycle: wait for an edge before driving again
    @(posedge clk);
    other_port_pin_in <= 1'b1;
    wr(PIN_FUNCTION_SELECT_ADDR, 8'h08);
    settle(2);
    chk("irq zero", {6'h00, ext_interrupt_zero_in, other_port_general_in}, 8'h02);
    @(posedge clk);
    wr(PIN_FUNCTION_SELECT_ADDR, 8'h00);
    settle(2);
    chk("plain input", {6'h00, ext_interrupt_zero_in, other_port_general_in}, 8'h01);
    @(posedge clk);
    serial_out_data <= 1'b1;
    wr(PIN_FUNCTION_SELECT_ADDR, 8'h04);
    settle(1);
    chk("serial release", {6'h00, serial_out_pullup_off, serial_output_pin_oe}, 8'h02);
    @(posedge clk);
    serial_out_data <= 1'b0;
    settle(1);
    chk("serial low", {6'h00, serial_output_pin_out, serial_output_pin_oe}, 8'h01);
    // a write while clk_en is low must leave the latch alone
    @(posedge clk);
    clk_en <= 1'b0;
    wr(PORT_DATA_LATCH_ADDR, 8'hff);
    clk_en <= 1'b1;
    settle(1);
    chk("frozen latch", port_pin_out, 8'h30);
    // second reset in mid-run with every register dirty
    @(posedge clk);
    ext_level <= 8'h5a;
    rst();
    chk("reset enable", port_pin_oe, 8'h00);
    chk("reset value", port_pin_out, 8'h00);
    rd(PIN_FUNCTION_SELECT_ADDR, v);
    chk("fs reset", v, PIN_FUNCTION_SELECT_RST);
    rd(OUTPUT_DRIVE_TYPE_ADDR, v);
    chk("drive reset", v, OUTPUT_DRIVE_TYPE_RST);
    rd(PORT_DATA_LATCH_ADDR, v);
    chk("input read", v, 8'h5a);
    wr(PIN_DIRECTION_ADDR, 8'hff);
    rd(PORT_DATA_LATCH_ADDR, v);
    chk("latch reset", v, PORT_DATA_LATCH_RST);
    test_done();
  end
endmodule : test_port2_gpio_and_pin_select

bind p2gp_top p2gp_top_sva p2gp_top_sva_i (
  .clk                   (clk),
  .reset_n               (reset_n),
  .clk_en                (clk_en),
  .reg_addr              (reg_addr),
  .reg_wdata             (reg_wdata),
  .reg_wr                (reg_wr),
  .reg_rd                (reg_rd),
  .reg_rdata             (reg_rdata),
  .port_pin_in           (port_pin_in),
  .port_pin_out          (port_pin_out),
  .port_pin_oe           (port_pin_oe),
  .other_port_pin_in     (other_port_pin_in),
  .other_port_general_in (other_port_general_in),
  .ext_interrupt_zero_in (ext_interrupt_zero_in),
  .updown_count_in       (updown_count_in),
  .ext_interrupt_four_in (ext_interrupt_four_in),
  .converter_ext_trigger (converter_ext_trigger),
  .serial_out_data       (serial_out_data),
  .serial_output_pin_out (serial_output_pin_out),
  .serial_output_pin_oe  (serial_output_pin_oe),
  .serial_out_pullup_off (serial_out_pullup_off)
);
